//--- logic/rdd_decoder.v
// receive descriptor fetch and word 1..3 decoder with wishbone registers
// assumes host memory answers reads on a classic request/ack port
`timescale 1ns/1ns
`include "rdd_map.vh"

module rdd_decoder #(
  parameter AW = 32
) (
  input  wire          mclk_i,
  input  wire          resetn_i,
  // wishbone slave
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  // host memory read port
  output reg           mem_req_o,
  output reg  [AW-1:0] mem_adr_o,
  input  wire [31:0]   mem_dat_i,
  input  wire          mem_ack_i,
  // decoded descriptor to data mover
  output reg           desc_valid_o,
  input  wire          desc_done_i,
  output reg  [AW-1:0] buf1_addr_o,
  output reg  [10:0]   buf1_size_o,
  output reg           buf1_use_o,
  output reg  [AW-1:0] buf2_addr_o,
  output reg  [10:0]   buf2_size_o,
  output reg           buf2_use_o,
  output reg           ring_end_o,
  output reg           chained_o,
  output reg  [AW-1:0] next_desc_o
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_HOLD  = 2'h2;

  reg [1:0]    state_r;
  reg          enable_r;
  reg [31:0]   base_r;
  reg [AW-1:0] cur_r;
  reg [1:0]    word_r;
  reg [31:0]   w1_r;
  reg [31:0]   w2_r;
  reg [15:0]   count_r;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_req & wb_we_i;

  // byte-lane merge for writes
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  sel;
    integer k;
    begin
      lane_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          lane_merge[k*8 +: 8] = data[k*8 +: 8];
        end
      end
    end
  endfunction

  // wishbone registers
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      enable_r <= `RDD_CTRL_RST;
      base_r   <= `RDD_BASE_RST;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_wr && wb_adr_i == `RDD_REG_CTRL && wb_sel_i[0]) begin
        enable_r <= wb_dat_i[0];
      end
      if (wb_wr && wb_adr_i == `RDD_REG_BASE) begin
        // list base kept 16-byte aligned
        base_r <= lane_merge(base_r, wb_dat_i, wb_sel_i) &
                  32'hFFFF_FFF0;
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `RDD_REG_CTRL:   wb_dat_o <= {31'h0000_0000, enable_r};
          `RDD_REG_BASE:   wb_dat_o <= base_r;
          `RDD_REG_STATUS: wb_dat_o <= {28'h000_0000, desc_valid_o,
                                        mem_req_o, state_r};
          `RDD_REG_CUR:    wb_dat_o <= cur_r[31:0];
          `RDD_REG_COUNT:  wb_dat_o <= {16'h0000, count_r};
          default:         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // decode of the three fetched words
  wire [31:0] w3        = mem_dat_i;
  wire        ring_end  = w1_r[`RDD_RING_END_BIT];
  // reserved bits of the control word are never looked at
  wire        chained   = w1_r[`RDD_CHAINED_BIT] & ~ring_end;
  wire [10:0] size1     = w1_r[`RDD_SIZE1_MSB:`RDD_SIZE1_LSB];
  wire [10:0] size2     = w1_r[`RDD_SIZE2_MSB:`RDD_SIZE2_LSB];
  wire        use1      = (size1 != 11'h000);

  // successor descriptor address
  reg [AW-1:0] next_addr;
  always @* begin
    if (ring_end) begin
      next_addr = base_r[AW-1:0];
    end else if (chained) begin
      next_addr = w3[AW-1:0];
    end else begin
      next_addr = cur_r + `RDD_DESC_STEP;
    end
  end

  // fetch sequencer: words 1..3 read in order, no write path exists
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_r      <= ST_IDLE;
      cur_r        <= {AW{1'b0}};
      word_r       <= 2'h0;
      w1_r         <= 32'h0000_0000;
      w2_r         <= 32'h0000_0000;
      count_r      <= `RDD_COUNT_RST;
      mem_req_o    <= 1'b0;
      mem_adr_o    <= {AW{1'b0}};
      desc_valid_o <= 1'b0;
      buf1_addr_o  <= {AW{1'b0}};
      buf1_size_o  <= 11'h000;
      buf1_use_o   <= 1'b0;
      buf2_addr_o  <= {AW{1'b0}};
      buf2_size_o  <= 11'h000;
      buf2_use_o   <= 1'b0;
      ring_end_o   <= 1'b0;
      chained_o    <= 1'b0;
      next_desc_o  <= {AW{1'b0}};
    end else begin
      case (state_r)
        ST_IDLE: begin
          cur_r <= base_r[AW-1:0];
          if (enable_r) begin
            state_r   <= ST_FETCH;
            word_r    <= 2'h1;
            mem_req_o <= 1'b1;
            mem_adr_o <= base_r[AW-1:0] + `RDD_WORD1_OFS;
          end
        end
        ST_FETCH: begin
          if (mem_req_o && mem_ack_i) begin
            // request dropped one cycle between words
            mem_req_o <= 1'b0;
            case (word_r)
              2'h1: w1_r <= mem_dat_i;
              2'h2: w2_r <= mem_dat_i;
              default: begin
                // all words in hand before any data moves
                buf1_addr_o <= w2_r[AW-1:0];
                buf1_size_o <= size1;
                buf1_use_o  <= use1;
                buf2_addr_o <= w3[AW-1:0];
                // size ignored when chained
                buf2_size_o <= chained ? 11'h000 : size2;
                buf2_use_o  <= ~chained;
                ring_end_o  <= ring_end;
                chained_o   <= chained;
                next_desc_o <= next_addr;
                desc_valid_o <= 1'b1;
                count_r     <= count_r + 16'h0001;
                state_r     <= ST_HOLD;
              end
            endcase
            word_r <= word_r + 2'h1;
          end else if (!mem_req_o) begin
            mem_req_o <= 1'b1;
            mem_adr_o <= mem_adr_o + `RDD_WORD_STEP;
          end
        end
        ST_HOLD: begin
          if (desc_done_i) begin
            desc_valid_o <= 1'b0;
            cur_r        <= next_desc_o;
            if (enable_r) begin
              // every new descriptor is fetched afresh
              state_r   <= ST_FETCH;
              word_r    <= 2'h1;
              mem_req_o <= 1'b1;
              mem_adr_o <= next_desc_o + `RDD_WORD1_OFS;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: begin
          state_r   <= ST_IDLE;
          mem_req_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- shared/rdd_map.vh
// constants for the receive descriptor word decoder
// assumes a 32-bit wishbone slave and a 32-bit read-only host port
`ifndef RDD_MAP_VH
`define RDD_MAP_VH

// control word field positions
`define RDD_RING_END_BIT    25
`define RDD_CHAINED_BIT     24
`define RDD_SIZE2_MSB       21
`define RDD_SIZE2_LSB       11
`define RDD_SIZE1_MSB       10
`define RDD_SIZE1_LSB       0

// byte offsets of descriptor words
`define RDD_WORD1_OFS       32'h0000_0004
`define RDD_WORD_STEP       32'h0000_0004
`define RDD_DESC_STEP       32'h0000_0010

// register byte offsets
`define RDD_REG_CTRL        8'h00
`define RDD_REG_BASE        8'h04
`define RDD_REG_STATUS      8'h08
`define RDD_REG_CUR         8'h0C
`define RDD_REG_COUNT       8'h10

// reset values
`define RDD_CTRL_RST        1'b0
`define RDD_BASE_RST        32'h0000_0000
`define RDD_COUNT_RST       16'h0000

`endif

//--- testbench/rdd_chk.sv
// port timing checker for rdd_decoder
// assumes it is bound onto rdd_decoder
`timescale 1ns/1ns
module rdd_chk #(
  parameter AW = 32
) (
  input wire          mclk_i,
  input wire          resetn_i,
  input wire          wb_cyc_i,
  input wire          wb_stb_i,
  input wire          wb_ack_o,
  input wire          mem_req_o,
  input wire [AW-1:0] mem_adr_o,
  input wire          mem_ack_i,
  input wire          desc_valid_o,
  input wire [10:0]   buf1_size_o,
  input wire          buf1_use_o,
  input wire [10:0]   buf2_size_o,
  input wire          buf2_use_o,
  input wire          ring_end_o,
  input wire          chained_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  a_wb_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
  a_req_hold: assert property (mem_req_o && !mem_ack_i
    |=> mem_req_o && $stable(mem_adr_o)) else $error("req dropped");
  a_req_gap: assert property (mem_req_o && mem_ack_i
    |=> !mem_req_o) else $error("no gap");
  a_word_step: assert property (
    mem_req_o && mem_ack_i && mem_adr_o[3:0] != 4'hC
    |=> ##1 mem_req_o && mem_adr_o == $past(mem_adr_o, 2) + 4)
    else $error("bad word step");
  a_valid_after: assert property (
    mem_req_o && mem_ack_i && mem_adr_o[3:0] == 4'hC
    |=> desc_valid_o) else $error("no decode");
  a_chain_eff: assert property (desc_valid_o && chained_o
    |-> !ring_end_o && !buf2_use_o && buf2_size_o == 11'h000)
    else $error("bad chain");
  a_buf1_use: assert property (desc_valid_o
    |-> buf1_use_o == (buf1_size_o != 11'h000)) else $error("buf1 use");
  a_no_refetch: assert property (desc_valid_o
    |-> !mem_req_o) else $error("fetch while held");
endmodule
bind rdd_decoder rdd_chk #(.AW(AW)) rdd_chk_inst (.*);

//--- testbench/rdd_mem.sv
// host memory model answering word reads
// assumes a request held until ack
`timescale 1ns/1ns
module rdd_mem (
  input  wire        clk_i,
  input  wire        req_i,
  input  wire [31:0] adr_i,
  input  wire        slow_i,
  output reg  [31:0] dat_o = 32'h0,
  output reg         ack_o = 1'b0
);
  reg [31:0] mem [0:63];
  reg [1:0]  wait_r = 2'h0;
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    // no stale word between answers
    dat_o <= ~dat_o;
    if (req_i && !ack_o) begin
      if (wait_r == (slow_i ? 2'h2 : 2'h0)) begin
        ack_o  <= 1'b1;
        dat_o  <= mem[adr_i[7:2]];
        wait_r <= 2'h0;
      end else
        wait_r <= wait_r + 2'h1;
    end
  end
endmodule

//--- testbench/test_rdd_decoder.sv
// bench for rdd_decoder: ring of descriptors
// assumes rdd_mem as host memory
`timescale 1ns/1ns
module test_rdd_decoder;
  typedef struct packed {
    logic [31:0] a, w1, w2, w3, nx;
    logic [3:0]  f;
    logic [10:0] s2;
  } rdd_row_t;
  reg         mclk_i, resetn_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  reg         wb_we_i = 1'b0, desc_done_i = 1'b0, slow = 1'b0;
  reg  [7:0]  wb_adr_i = 8'h00;
  reg  [3:0]  wb_sel_i = 4'hF;
  reg  [31:0] wb_dat_i = 32'h0, q;
  wire [31:0] wb_dat_o, mem_adr_o, mem_dat_i, buf1_addr_o, buf2_addr_o;
  wire [31:0] next_desc_o;
  wire [10:0] buf1_size_o, buf2_size_o;
  wire        wb_ack_o, mem_req_o, mem_ack_i, desc_valid_o, buf1_use_o;
  wire        buf2_use_o, ring_end_o, chained_o;
  rdd_row_t   rows [0:4];
  rdd_row_t   r;
  integer     i, num_errors = 0, checks_done = 0, cycles = 0;
  rdd_decoder rdd_decoder_inst (.*);
  rdd_mem rdd_mem_inst (.clk_i(mclk_i), .req_i(mem_req_o),
    .adr_i(mem_adr_o), .slow_i(slow), .dat_o(mem_dat_i), .ack_o(mem_ack_i));
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  task cmp(input [63:0] nm, input [31:0] e, input [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d, output [31:0] rd);
    @(posedge mclk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    @(posedge mclk_i);
    while (wb_ack_o !== 1'b1) @(posedge mclk_i);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  initial begin
    rows[0] = {32'h40, 32'h8020, 32'h1003, 32'h2000, 32'h50, 4'hC, 11'h10};
    rows[1] = {32'h50, 32'h100_0040, 32'h1101, 32'h80, 32'h80, 4'h9, 11'h0};
    rows[2] = {32'h80, 32'h4000, 32'h1202, 32'h3000, 32'h90, 4'h4, 11'h8};
    rows[3] = {32'h90, 32'h300_2010, 32'h1300, 32'h4000, 32'h40, 4'hE, 11'h4};
    rows[4] = rows[0];
    for (i = 0; i < 4; i = i + 1) begin
      r = rows[i];
      rdd_mem_inst.mem[r.a[7:2] + 1] = r.w1;
      rdd_mem_inst.mem[r.a[7:2] + 2] = r.w2;
      rdd_mem_inst.mem[r.a[7:2] + 3] = r.w3;
    end
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    cmp("rstout", 0, {mem_req_o, desc_valid_o});
    wb(0, 8'h00, 0, q);
    cmp("ctrl", 0, q);
    wb(1, 8'h04, 32'h40, q);
    wb(1, 8'h00, 32'h1, q);
    for (i = 0; i < 5; i = i + 1) begin
      r = rows[i];
      slow <= i[0];
      while (mem_req_o !== 1'b1) @(posedge mclk_i);
      cmp("fetch", r.a + 4, mem_adr_o);
      while (desc_valid_o !== 1'b1) @(posedge mclk_i);
      cmp("ptr1", r.w2, buf1_addr_o);
      cmp("ptr2", r.w3, buf2_addr_o);
      cmp("size1", r.w1[10:0], buf1_size_o);
      cmp("size2", r.s2, buf2_size_o);
      cmp("flags", r.f, {buf1_use_o, buf2_use_o, ring_end_o, chained_o});
      cmp("next", r.nx, next_desc_o);
      if (i == 4) wb(1, 8'h00, 0, q);
      desc_done_i <= 1'b1;
      @(posedge mclk_i);
      desc_done_i <= 1'b0;
    end
    repeat (8) @(posedge mclk_i);
    cmp("idle", 0, mem_req_o);
    wb(0, 8'h04, 0, q);
    cmp("base", 32'h40, q);
    wb(0, 8'h10, 0, q);
    cmp("count", 5, q);
    wb(0, 8'h0C, 0, q);
    cmp("cur", 32'h40, q);
    wb(0, 8'h08, 0, q);
    cmp("status", 0, q);
    wb(1, 8'h20, 32'hFFFF_FFFF, q);
    wb(0, 8'h20, 0, q);
    cmp("unmapped", 0, q);
    test_done;
  end
endmodule
